// ===== rtl/acc_top.sv
// Function
// - control bit 7 enables the converter; zero disables it
// - control bit 6 selects scanning versus non-scanning operation
// - writing one to trigger bit 0 starts the selected conversions; after a non-scanning run it is ignored until enable is toggled
// - in non-scanning mode trigger bit 0 stays set after conversion
// - control bit 4 sets once commanded conversions have finished
// - interrupt raised on completion only when control bit 3 is one
// - per-channel flags show which channels got new results
`timescale 1ns/10ps
`include "acc_consts.svh"
module acc_top (
  input  wire logic                     CLK,
  input  wire logic                     RST_N,
  input  wire logic                     HSEL,
  input  wire logic [31:0]              HADDR,
  input  wire logic [1:0]               HTRANS,
  input  wire logic                     HWRITE,
  input  wire logic [2:0]               HSIZE,
  input  wire logic [31:0]              HWDATA,
  input  wire logic                     HREADY,
  input  wire logic [`ACC_NCHAN*10-1:0] AIN,
  output logic      [31:0]              HRDATA,
  output logic                          HREADYOUT,
  output logic                          HRESP,
  output logic                          IRQ,
  output logic      [`ACC_NCHAN*10-1:0] RESULT
);
  typedef struct packed {
    logic [7:0]       ctrl;
    logic [7:0]       trig;
    logic [7:0]       avail;
    logic [7:0]       chan_sel;
    logic [7:0]       irq_stat;
    logic [7:0]       irq_mask;
    acc_pkg::acc_seq_t seq;
    logic [2:0]       chan;
    logic [4:0]       cnt;
    logic             wr_pend;
    logic             rd_pend;
    logic [11:0]      addr;
    logic [31:0]      rdata;
    logic             irq;
    logic             readyout;
    logic             resp;
  } acc_state_t;

  acc_state_t                st;
  acc_state_t                next_st;
  logic      [`ACC_NCHAN-1:0] capture;
  logic                      take;
  logic                      done_evt;
  logic      [7:0]           wdata;

  assign take  = HSEL && HREADY && HTRANS[1];
  assign wdata = HWDATA[7:0];

  // pick the lowest selected channel at or above the given index
  function automatic logic [3:0] acc_find(input logic [7:0] sel, input logic [3:0] from);
    logic [3:0] r;
    r = `ACC_CHAN_NONE;
    for (int i = 7; i >= 0; i--) begin
      if (sel[i] && (4'(i) >= from)) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  always_comb begin
    logic [3:0] first;
    logic [3:0] nxt;
    first    = acc_find(st.chan_sel, 4'h0);
    nxt      = acc_find(st.chan_sel, {1'b0, st.chan} + 4'h1);
    next_st  = st;
    capture  = '0;
    done_evt = 1'b0;
    next_st.rdata = 32'h0000_0000;

    // address phase capture
    next_st.wr_pend = take && HWRITE;
    next_st.rd_pend = take && !HWRITE;
    if (take) begin
      next_st.addr = HADDR[11:0];
    end

    // sequencer
    unique case (st.seq)
      acc_pkg::ACC_IDLE: begin
        if (st.ctrl[`ACC_CTRL_EN] && st.trig[`ACC_TRIG_START] && !st.ctrl[`ACC_CTRL_DONE] && first != `ACC_CHAN_NONE) begin
          next_st.seq   = acc_pkg::ACC_CONV;
          next_st.chan  = first[2:0];
          next_st.cnt   = `ACC_CONV_CYCLES;
          next_st.avail = `ACC_AVAIL_RST;
        end
      end
      acc_pkg::ACC_CONV: begin
        if (st.cnt == `ACC_CONV_ONE) begin
          next_st.seq = acc_pkg::ACC_NEXT;
        end
        next_st.cnt = st.cnt - `ACC_CONV_ONE;
      end
      acc_pkg::ACC_NEXT: begin
        capture[st.chan] = 1'b1;
        next_st.avail[st.chan] = 1'b1;
        if (nxt != `ACC_CHAN_NONE) begin
          next_st.seq  = acc_pkg::ACC_CONV;
          next_st.chan = nxt[2:0];
          next_st.cnt  = `ACC_CONV_CYCLES;
        end else begin
          done_evt = 1'b1;
          next_st.ctrl[`ACC_CTRL_DONE] = 1'b1;
          if (st.ctrl[`ACC_CTRL_SCAN]) begin
            next_st.trig[`ACC_TRIG_START] = 1'b0;
            // an emptied selection ends the scan instead of converting channel zero
            next_st.seq = acc_pkg::ACC_IDLE;
            if (first != `ACC_CHAN_NONE) begin
              next_st.seq  = acc_pkg::ACC_CONV;
              next_st.chan = first[2:0];
              next_st.cnt  = `ACC_CONV_CYCLES;
            end
          end else begin
            next_st.seq = acc_pkg::ACC_HOLD;
          end
        end
      end
      acc_pkg::ACC_HOLD: begin
        // parked until software toggles enable; a retrigger is ignored here
        next_st.seq = acc_pkg::ACC_HOLD;
      end
    endcase

    // data phase writes
    if (st.wr_pend) begin
      unique case (st.addr)
        `ACC_OFS_CTRL: begin
          next_st.ctrl[`ACC_CTRL_EN]     = wdata[`ACC_CTRL_EN];
          next_st.ctrl[`ACC_CTRL_SCAN]   = wdata[`ACC_CTRL_SCAN];
          next_st.ctrl[`ACC_CTRL_IRQ_EN] = wdata[`ACC_CTRL_IRQ_EN];
          // done flag clears by writing zero; a same-cycle completion wins
          if (!wdata[`ACC_CTRL_DONE] && !done_evt) begin
            next_st.ctrl[`ACC_CTRL_DONE] = 1'b0;
          end
        end
        `ACC_OFS_TRIG: begin
          next_st.trig = {7'h00, wdata[`ACC_TRIG_START]};
          // a completion in the same cycle keeps the done flag
          if (wdata[`ACC_TRIG_START] && !done_evt) begin
            next_st.ctrl[`ACC_CTRL_DONE] = 1'b0;
          end
        end
        `ACC_OFS_IRQ_MASK: next_st.irq_mask = wdata;
        `ACC_OFS_CHAN_SEL: next_st.chan_sel = wdata;
        default: begin
        end
      endcase
    end

    if (!next_st.ctrl[`ACC_CTRL_EN]) begin
      next_st.seq  = acc_pkg::ACC_IDLE;
      next_st.trig = `ACC_TRIG_RST;
      next_st.cnt  = `ACC_CONV_ZERO;
    end

    // read data includes a write landing in this cycle, so back-to-back access stays coherent
    if (take && !HWRITE) begin
      unique case (HADDR[11:0])
        `ACC_OFS_CTRL:     next_st.rdata = {24'h0, next_st.ctrl};
        `ACC_OFS_TRIG:     next_st.rdata = {24'h0, next_st.trig};
        `ACC_OFS_AVAIL:    next_st.rdata = {24'h0, next_st.avail};
        `ACC_OFS_IRQ_STAT: next_st.rdata = {24'h0, next_st.irq_stat};
        `ACC_OFS_IRQ_MASK: next_st.rdata = {24'h0, next_st.irq_mask};
        `ACC_OFS_CHAN_SEL: next_st.rdata = {24'h0, next_st.chan_sel};
        default:           next_st.rdata = 32'h0000_0000;
      endcase
    end

    // read of status clears it; a same-cycle event wins
    if (take && !HWRITE && HADDR[11:0] == `ACC_OFS_IRQ_STAT) begin
      next_st.irq_stat = `ACC_STAT_RST;
    end
    if (done_evt && st.ctrl[`ACC_CTRL_IRQ_EN]) begin
      next_st.irq_stat[`ACC_IRQ_DONE] = 1'b1;
    end
    next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
    // no wait states and no error response, but both still leave a flip-flop
    next_st.readyout = `ACC_READY_RST;
    next_st.resp     = `ACC_RESP_OKAY;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st.ctrl     <= `ACC_CTRL_RST;
      st.trig     <= `ACC_TRIG_RST;
      st.avail    <= `ACC_AVAIL_RST;
      st.chan_sel <= `ACC_CHAN_RST;
      st.irq_stat <= `ACC_STAT_RST;
      st.irq_mask <= `ACC_MASK_RST;
      st.seq      <= acc_pkg::ACC_IDLE;
      st.chan     <= 3'h0;
      st.cnt      <= `ACC_CONV_ZERO;
      st.wr_pend  <= 1'b0;
      st.rd_pend  <= 1'b0;
      st.addr     <= 12'h000;
      st.rdata    <= 32'h0000_0000;
      st.irq      <= 1'b0;
      st.readyout <= `ACC_READY_RST;
      st.resp     <= `ACC_RESP_OKAY;
    end else begin
      st <= next_st;
    end
  end

  acc_sampler u_smp (
    .CLK     (CLK),
    .RST_N   (RST_N),
    .capture (capture),
    .ain     (AIN),
    .result  (RESULT)
  );

  assign HRDATA    = st.rdata;
  assign HREADYOUT = st.readyout;
  assign HRESP     = st.resp;
  assign IRQ       = st.irq;
endmodule

// ===== rtl/acc_consts.svh
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH
// register byte offsets
`define ACC_OFS_CTRL      12'h000
`define ACC_OFS_TRIG      12'h004
`define ACC_OFS_AVAIL     12'h008
`define ACC_OFS_IRQ_STAT  12'h00C
`define ACC_OFS_IRQ_MASK  12'h010
`define ACC_OFS_CHAN_SEL  12'h014
// control and trigger register fields
`define ACC_CTRL_EN       7
`define ACC_CTRL_SCAN     6
`define ACC_CTRL_DONE     4
`define ACC_CTRL_IRQ_EN   3
`define ACC_TRIG_START    0
// interrupt status fields
`define ACC_IRQ_DONE      0
// reset values
`define ACC_CTRL_RST      8'h00
`define ACC_TRIG_RST      8'h00
`define ACC_AVAIL_RST     8'h00
`define ACC_MASK_RST      8'h00
`define ACC_CHAN_RST      8'h01
`define ACC_STAT_RST      8'h00
`define ACC_READY_RST     1'b1
`define ACC_RESP_OKAY     1'b0
// search result meaning no selected channel remains
`define ACC_CHAN_NONE     4'h8
// channel count and cycles per channel conversion
`define ACC_NCHAN         8
`define ACC_CONV_CYCLES   5'h10
`define ACC_CONV_ONE      5'h01
`define ACC_CONV_ZERO     5'h00
`endif

// ===== rtl/acc_pkg.sv
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_CONV,
    ACC_NEXT,
    ACC_HOLD
  } acc_seq_t;
endpackage

// ===== rtl/acc_sampler.sv
`timescale 1ns/10ps
`include "acc_consts.svh"
// per-channel sample stage: captures the analog input word when told
module acc_sampler (
  input  wire logic                     CLK,
  input  wire logic                     RST_N,
  input  wire logic [`ACC_NCHAN-1:0]    capture,
  input  wire logic [`ACC_NCHAN*10-1:0] ain,
  output logic      [`ACC_NCHAN*10-1:0] result
);
  typedef struct packed {
    logic [`ACC_NCHAN*10-1:0] res;
  } acc_smp_t;
  acc_smp_t st;
  acc_smp_t next_st;
  always_comb begin
    next_st = st;
    for (int i = 0; i < `ACC_NCHAN; i++) begin
      if (capture[i]) begin
        next_st.res[i*10 +: 10] = ain[i*10 +: 10];
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign result = st.res;
endmodule

// ===== verif/acc_checker.sv
`timescale 1ns/10ps
module acc_checker (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        IRQ
);
  logic        wr_q;
  logic [11:0] adr_q;
  logic [1:0]  en_scan;
  logic        mask0;
  wire         take = HSEL && HREADY && HTRANS[1];
  // shadows of bus-written bits, updated at the write's data-phase edge like the registers
  always_ff @(posedge CLK) begin
    wr_q <= RST_N && take && HWRITE;
    adr_q <= HADDR[11:0];
    if (!RST_N) begin
      en_scan <= 2'h0;
      mask0 <= 1'h0;
    end else if (wr_q && adr_q == 12'h000) begin
      en_scan <= HWDATA[7:6];
    end else if (wr_q && adr_q == 12'h010) begin
      mask0 <= HWDATA[0];
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_rd(logic [11:0] x);
    take && !HWRITE && HADDR[11:0] == x;
  endsequence
  property p_rdy; HREADYOUT; endproperty
  a_rdy: assert property (p_rdy) else $error("wait state inserted");
  property p_resp; !HRESP; endproperty
  a_resp: assert property (p_resp) else $error("error response given");
  property p_idle; !(take && !HWRITE) |=> HRDATA == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside data phase");
  property p_unmap; s_rd(12'h018) |=> HRDATA == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_upper; take && !HWRITE |=> HRDATA[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_ctrl; s_rd(12'h000) |=> HRDATA[7:6] == en_scan; endproperty
  a_ctrl: assert property (p_ctrl) else $error("enable or scan bit lost");
  property p_stat; s_rd(12'h00C) ##0 IRQ |=> HRDATA[0]; endproperty
  a_stat: assert property (p_stat) else $error("irq without status bit");
  property p_mask; IRQ |-> $past(mask0); endproperty
  a_mask: assert property (p_mask) else $error("masked irq raised");
  property p_rst; $rose(RST_N) |-> !IRQ && HRDATA == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule
bind acc_top acc_checker acc_checker_i (.CLK, .RST_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA, .HREADY,
  .HRDATA, .HREADYOUT, .HRESP, .IRQ);

// ===== verif/test_adc_conversion_control.sv
`timescale 1ns/10ps
module test_adc_conversion_control;
  logic        CLK, RST_N, HSEL, HWRITE;
  logic [31:0] HADDR, HWDATA, HRDATA, d;
  logic [1:0]  HTRANS;
  logic [79:0] AIN, RESULT;
  logic        HREADYOUT, HRESP, IRQ;
  wire         HREADY = HREADYOUT;
  int          n_errors, comparisons, cyc;
  acc_top acc_top_i (.CLK, .RST_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA, .HREADY, .AIN,
    .HRDATA, .HREADYOUT, .HRESP, .IRQ, .RESULT);
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  task report_and_stop;
    $display("counts: %0d mismatches in %0d comparisons", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors++;
      report_and_stop;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  // address phase held until hready, then data phase held until hready
  task bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    HSEL <= 1'h1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {20'h0, a};
    do @(posedge CLK); while (HREADY !== 1'h1);
    HSEL <= 1'h0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge CLK); while (HREADY !== 1'h1);
    d = HRDATA;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] v);
    bus(1'h1, a, v);
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(d, e);
  endtask
  task wirq;
    for (int i = 0; i < 200 && IRQ !== 1'h1; i++) @(posedge CLK);
    chk(32'(IRQ), 32'h1);
  endtask
  initial begin
    {RST_N, HSEL, HWRITE, HTRANS, HADDR, HWDATA, n_errors, comparisons, cyc} = '0;
    AIN = {8{10'h155}};
    repeat (2) @(posedge CLK);
    RST_N <= 1'h1;
    // last offset is unmapped; channel select resets to one
    for (int i = 0; i < 7; i++) rc(12'(i * 4), 32'(i == 5));
    $display("reset values done");
    wr(12'h000, 32'hC8);
    rc(12'h000, 32'hC8);
    wr(12'h000, 32'h00);
    rc(12'h000, 32'h00);
    $display("control bits done");
    wr(12'h014, 32'h05);
    wr(12'h010, 32'h01);
    wr(12'h000, 32'h88);
    wr(12'h004, 32'h01);
    wirq;
    rc(12'h000, 32'h98);
    rc(12'h004, 32'h01);
    rc(12'h008, 32'h05);
    chk(32'(RESULT[29:20]), 32'h155);
    rc(12'h00C, 32'h01);
    rc(12'h00C, 32'h00);
    chk(32'(IRQ), 32'h0);
    $display("non-scanning conversion done");
    // a second trigger while stuck must not start anything
    wr(12'h000, 32'h88);
    AIN <= {8{10'h2AA}};
    wr(12'h004, 32'h01);
    repeat (60) @(posedge CLK);
    rc(12'h000, 32'h88);
    chk(32'(RESULT[9:0]), 32'h155);
    wr(12'h000, 32'h08);
    rc(12'h004, 32'h00);
    wr(12'h000, 32'h88);
    wr(12'h004, 32'h01);
    wirq;
    chk(32'(RESULT[9:0]), 32'h2AA);
    rc(12'h00C, 32'h01);
    $display("re-enable sequence done");
    // a masked completion is still recorded, but the pin stays low
    wr(12'h010, 32'h00);
    wr(12'h000, 32'h08);
    wr(12'h000, 32'h88);
    wr(12'h004, 32'h01);
    repeat (60) @(posedge CLK);
    chk(32'(IRQ), 32'h0);
    rc(12'h00C, 32'h01);
    rc(12'h000, 32'h98);
    $display("masked interrupt done");
    wr(12'h000, 32'h00);
    wr(12'h000, 32'hC0);
    wr(12'h004, 32'h01);
    d = 32'h0;
    for (int i = 0; i < 60 && d[4] !== 1'h1; i++) bus(1'h0, 12'h000, 32'h0);
    chk(d, 32'hD0);
    rc(12'h004, 32'h00);
    chk(32'(IRQ), 32'h0);
    rc(12'h00C, 32'h00);
    $display("scanning without interrupt done");
    report_and_stop;
  end
endmodule
